// ===== include/ttc_pkg.sv
// package: constants and types for the triple timer counter unit
`default_nettype none
package ttc_pkg;
  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_TCTRL  = 8'h88;
  localparam logic [7:0] ADDR_TMODE  = 8'h89;
  localparam logic [7:0] ADDR_C0_LO  = 8'h8a;
  localparam logic [7:0] ADDR_TL1    = 8'h8b;
  localparam logic [7:0] ADDR_C0_HI  = 8'h8c;
  localparam logic [7:0] ADDR_TH1    = 8'h8d;
  localparam logic [7:0] ADDR_T2CTRL = 8'hc8;
  localparam logic [7:0] ADDR_RLD_LO = 8'hca;
  localparam logic [7:0] ADDR_RLD_HI = 8'hcb;
  localparam logic [7:0] ADDR_C2_LO  = 8'hcc;
  localparam logic [7:0] ADDR_C2_HI  = 8'hcd;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int TC_OV1 = 7;
  localparam int TC_RN1 = 6;
  localparam int TC_OV0 = 5;
  localparam int TC_RN0 = 4;
  localparam int TM_GATE = 3;
  localparam int TM_CT   = 2;
  localparam int TM_HALF = 4;
  localparam int C2_TF  = 7;
  localparam int C2_EXF = 6;
  localparam int C2_RCK = 5;
  localparam int C2_TCK = 4;
  localparam int C2_EXE = 3;
  localparam int C2_TR  = 2;
  localparam int C2_CNT = 1;
  localparam int C2_CAP = 0;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [4:0] PRE_ONES  = 5'h1f;
  // ------------------------------------------------------------
  // modes and timing
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_13B   = 2'h0;
  localparam logic [1:0] MODE_16B   = 2'h1;
  localparam logic [1:0] MODE_RELD  = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [3:0] MCYC_DIV   = 4'hc;
  localparam logic [3:0] MCYC_LAST  = MCYC_DIV - 4'h1;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } ttc_sfr_req_t;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ovf;
  } ttc_cnt_t;
endpackage : ttc_pkg
`default_nettype wire

// ===== design/ttc_top.sv
// design: three timer/counters behind special function registers
// ------------------------------------------------------------
// What this block does
// R1 - 13-bit count: high byte plus five low
// R2 - 13-bit mode: divide-by-32 prescale then eight bits
// R3 - wrap to zero sets overflow flag
// R4 - count only while run and gate allows
// R5 - setting run keeps the present count
// R6 - mode 1 uses all 16 bits
// R7 - mode 2: low byte reloads from high
// R8 - timer 1 in mode 3 holds count
// R9 - split low byte uses timer 0 controls
// R10 - split high byte: machine cycles, timer 1 bits
// R11 - timer 1 runs via mode, still baud source
// R12 - timer 2 flag set unless serial clocking
// R13 - trigger flag set on enabled falling edge
// R14 - receive clock from timer 2 or 1
// R15 - transmit clock from timer 2 or 1
// R16 - trigger enable gates capture or reload
// R17 - timer 2 run bit starts and stops
// R18 - timer 2 counts pin or core clock
// R19 - select capture or autoreload on trigger
// R20 - serial clocking forces autoreload on overflow
// R21 - autoreload copies reload pair into count
// R22 - capture copies count into reload pair
// R23 - interrupt entry clears timers 0/1 flags
// R24 - mode register: two-bit mode, counter select
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module ttc_top (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rstn_i,
  input  wire ttc_pkg::ttc_sfr_req_t sfr_req_i,
  input  wire logic                  ext_interrupt0_pin_i,
  input  wire logic                  ext_interrupt1_pin_i,
  input  wire logic                  timer0_count_pin_i,
  input  wire logic                  timer1_count_pin_i,
  input  wire logic                  timer2_count_pin_i,
  input  wire logic                  timer2_trigger_pin_i,
  input  wire logic                  timer0_int_ack_i,
  input  wire logic                  timer1_int_ack_i,
  output logic [7:0]                 sfr_rdata_o,
  output logic                       timer0_overflow_flag_o,
  output logic                       timer1_overflow_flag_o,
  output logic                       timer2_overflow_flag_o,
  output logic                       timer2_trigger_flag_o,
  output logic                       serial_rx_clock_o,
  output logic                       serial_tx_clock_o
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic wr_hit(input ttc_pkg::ttc_sfr_req_t req, input logic [7:0] adr);
    wr_hit = req.wr && (req.addr == adr);
  endfunction : wr_hit

  // one count step for modes 0..3 (mode 3: low byte only)
  function automatic ttc_pkg::ttc_cnt_t step(input logic [1:0] md, input logic [7:0] hi,
                                             input logic [7:0] lo);
    ttc_pkg::ttc_cnt_t r;
    r.hi  = hi;
    r.lo  = lo;
    r.ovf = 1'b0;
    case (md)
      ttc_pkg::MODE_13B: begin
        r.lo[4:0] = lo[4:0] + 5'h01; // [R1] [R2]
        if (lo[4:0] == ttc_pkg::PRE_ONES) begin
          r.hi  = hi + 8'h01;
          r.ovf = (hi == ttc_pkg::BYTE_ONES); // [R3]
        end
      end
      ttc_pkg::MODE_16B: begin
        {r.hi, r.lo} = {hi, lo} + 16'h0001; // [R6]
        r.ovf = ({hi, lo} == {ttc_pkg::BYTE_ONES, ttc_pkg::BYTE_ONES}); // [R3]
      end
      ttc_pkg::MODE_RELD: begin
        r.ovf = (lo == ttc_pkg::BYTE_ONES);
        r.lo  = r.ovf ? hi : lo + 8'h01; // [R7]
      end
      default: begin
        r.lo  = lo + 8'h01;
        r.ovf = (lo == ttc_pkg::BYTE_ONES);
      end
    endcase
    return r;
  endfunction : step

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] tctrl_r;
  logic [7:0] tmode_r;
  logic [7:0] c0_lo_r;
  logic [7:0] c0_hi_r;
  logic [7:0] tl1_r;
  logic [7:0] th1_r;
  logic [7:0] t2ctrl_r;
  logic [7:0] rld_lo_r;
  logic [7:0] rld_hi_r;
  logic [7:0] c2_lo_r;
  logic [7:0] c2_hi_r;
  logic [3:0] mcyc_cnt_r;
  logic       mcyc_en_r;
  logic [3:0] pin_prev_r;

  // ------------------------------------------------------------
  // machine cycle divider and pin edges
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mcyc_cnt_r <= '0;
      mcyc_en_r  <= 1'b0;
    end else begin
      mcyc_en_r  <= (mcyc_cnt_r == ttc_pkg::MCYC_LAST);
      mcyc_cnt_r <= (mcyc_cnt_r == ttc_pkg::MCYC_LAST) ? 4'h0 : mcyc_cnt_r + 4'h1;
    end
  end

  logic [3:0] pin_now;
  logic [3:0] pin_fall;
  assign pin_now  = {timer2_trigger_pin_i, timer2_count_pin_i, timer1_count_pin_i, timer0_count_pin_i};
  assign pin_fall = pin_prev_r & ~pin_now;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_prev_r <= '0;
    end else begin
      pin_prev_r <= pin_now;
    end
  end

  // ------------------------------------------------------------
  // timer 0 and 1 enables
  // ------------------------------------------------------------
  logic [1:0] md0;
  logic [1:0] md1;
  logic       split;
  logic       en0;
  logic       en1;
  logic       en0h;
  assign md0   = tmode_r[1:0]; // [R24]
  assign md1   = tmode_r[ttc_pkg::TM_HALF+1:ttc_pkg::TM_HALF]; // [R24]
  assign split = (md0 == ttc_pkg::MODE_SPLIT);
  assign en0   = tctrl_r[ttc_pkg::TC_RN0]
               && (!tmode_r[ttc_pkg::TM_GATE] || ext_interrupt0_pin_i) // [R4] [R9]
               && (tmode_r[ttc_pkg::TM_CT] ? pin_fall[0] : mcyc_en_r); // [R24]
  assign en1   = (split || tctrl_r[ttc_pkg::TC_RN1]) // [R11]
               && (!tmode_r[ttc_pkg::TM_HALF+ttc_pkg::TM_GATE] || ext_interrupt1_pin_i) // [R4]
               && (tmode_r[ttc_pkg::TM_HALF+ttc_pkg::TM_CT] ? pin_fall[1] : mcyc_en_r)
               && (md1 != ttc_pkg::MODE_SPLIT); // [R8] [R11]
  assign en0h  = split && tctrl_r[ttc_pkg::TC_RN1] && mcyc_en_r; // [R10]

  ttc_pkg::ttc_cnt_t nx0;
  ttc_pkg::ttc_cnt_t nx1;
  logic              ovf0;
  logic              ovf0h;
  logic              ovf1;
  assign nx0   = step(md0, c0_hi_r, c0_lo_r);
  assign nx1   = step(md1, th1_r, tl1_r);
  assign ovf0  = en0 && nx0.ovf; // [R3]
  assign ovf0h = en0h && (c0_hi_r == ttc_pkg::BYTE_ONES); // [R10]
  assign ovf1  = en1 && nx1.ovf;

  // ------------------------------------------------------------
  // timer 0 count
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      c0_lo_r <= ttc_pkg::RST_BYTE;
      c0_hi_r <= ttc_pkg::RST_BYTE;
    end else begin
      if (wr_hit(sfr_req_i, ttc_pkg::ADDR_C0_LO)) begin
        c0_lo_r <= sfr_req_i.wdata;
      end else if (en0) begin
        c0_lo_r <= nx0.lo; // [R9] [R5]
      end
      if (wr_hit(sfr_req_i, ttc_pkg::ADDR_C0_HI)) begin
        c0_hi_r <= sfr_req_i.wdata;
      end else if (en0h) begin
        c0_hi_r <= c0_hi_r + 8'h01; // [R10]
      end else if (en0 && !split) begin
        c0_hi_r <= nx0.hi;
      end
    end
  end

  // ------------------------------------------------------------
  // timer 1 count
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tl1_r <= ttc_pkg::RST_BYTE;
      th1_r <= ttc_pkg::RST_BYTE;
    end else begin
      if (wr_hit(sfr_req_i, ttc_pkg::ADDR_TL1)) begin
        tl1_r <= sfr_req_i.wdata;
      end else if (en1) begin
        tl1_r <= nx1.lo;
      end
      if (wr_hit(sfr_req_i, ttc_pkg::ADDR_TH1)) begin
        th1_r <= sfr_req_i.wdata;
      end else if (en1) begin
        th1_r <= nx1.hi;
      end
    end
  end

  // ------------------------------------------------------------
  // control and mode registers, timer 0/1 flags
  // ------------------------------------------------------------
  logic set_tf0;
  logic set_tf1;
  assign set_tf0 = ovf0;
  assign set_tf1 = split ? ovf0h : ovf1; // [R10]

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tctrl_r <= ttc_pkg::RST_BYTE;
    end else begin
      if (wr_hit(sfr_req_i, ttc_pkg::ADDR_TCTRL)) begin
        tctrl_r <= sfr_req_i.wdata; // [R5]
      end
      if (timer0_int_ack_i) begin
        tctrl_r[ttc_pkg::TC_OV0] <= 1'b0; // [R23]
      end
      if (timer1_int_ack_i) begin
        tctrl_r[ttc_pkg::TC_OV1] <= 1'b0; // [R23]
      end
      if (set_tf0) begin
        tctrl_r[ttc_pkg::TC_OV0] <= 1'b1; // [R3]
      end
      if (set_tf1) begin
        tctrl_r[ttc_pkg::TC_OV1] <= 1'b1; // [R3]
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tmode_r <= ttc_pkg::RST_BYTE;
    end else if (wr_hit(sfr_req_i, ttc_pkg::ADDR_TMODE)) begin
      tmode_r <= sfr_req_i.wdata; // [R24]
    end
  end

  // ------------------------------------------------------------
  // timer 2
  // ------------------------------------------------------------
  logic baud;
  logic en2;
  logic ovf2;
  logic trig;
  logic do_cap;
  logic do_rld;
  assign baud   = t2ctrl_r[ttc_pkg::C2_RCK] || t2ctrl_r[ttc_pkg::C2_TCK];
  assign en2    = t2ctrl_r[ttc_pkg::C2_TR] // [R17]
               && (t2ctrl_r[ttc_pkg::C2_CNT] ? pin_fall[2] : 1'b1); // [R18]
  assign ovf2   = en2 && ({c2_hi_r, c2_lo_r} == {ttc_pkg::BYTE_ONES, ttc_pkg::BYTE_ONES});
  assign trig   = t2ctrl_r[ttc_pkg::C2_EXE] && pin_fall[3]; // [R16]
  assign do_cap = trig && !baud && t2ctrl_r[ttc_pkg::C2_CAP]; // [R19] [R22]
  assign do_rld = (ovf2 && (baud || !t2ctrl_r[ttc_pkg::C2_CAP])) // [R20] [R21]
               || (trig && !baud && !t2ctrl_r[ttc_pkg::C2_CAP]); // [R19] [R16]

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      c2_lo_r <= ttc_pkg::RST_BYTE;
      c2_hi_r <= ttc_pkg::RST_BYTE;
    end else begin
      if (wr_hit(sfr_req_i, ttc_pkg::ADDR_C2_LO)) begin
        c2_lo_r <= sfr_req_i.wdata;
      end else if (do_rld) begin
        c2_lo_r <= rld_lo_r; // [R21]
      end else if (en2) begin
        c2_lo_r <= c2_lo_r + 8'h01;
      end
      if (wr_hit(sfr_req_i, ttc_pkg::ADDR_C2_HI)) begin
        c2_hi_r <= sfr_req_i.wdata;
      end else if (do_rld) begin
        c2_hi_r <= rld_hi_r; // [R21]
      end else if (en2 && (c2_lo_r == ttc_pkg::BYTE_ONES)) begin
        c2_hi_r <= c2_hi_r + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rld_lo_r <= ttc_pkg::RST_BYTE;
      rld_hi_r <= ttc_pkg::RST_BYTE;
    end else begin
      if (wr_hit(sfr_req_i, ttc_pkg::ADDR_RLD_LO)) begin
        rld_lo_r <= sfr_req_i.wdata;
      end else if (do_cap) begin
        rld_lo_r <= c2_lo_r; // [R22]
      end
      if (wr_hit(sfr_req_i, ttc_pkg::ADDR_RLD_HI)) begin
        rld_hi_r <= sfr_req_i.wdata;
      end else if (do_cap) begin
        rld_hi_r <= c2_hi_r; // [R22]
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      t2ctrl_r <= ttc_pkg::RST_BYTE;
    end else begin
      if (wr_hit(sfr_req_i, ttc_pkg::ADDR_T2CTRL)) begin
        t2ctrl_r <= sfr_req_i.wdata;
      end
      if (ovf2 && !baud) begin
        t2ctrl_r[ttc_pkg::C2_TF] <= 1'b1; // [R12]
      end
      if (trig) begin
        t2ctrl_r[ttc_pkg::C2_EXF] <= 1'b1; // [R13]
      end
    end
  end

  // ------------------------------------------------------------
  // serial clock routing and flag outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_rx_clock_o <= 1'b0;
      serial_tx_clock_o <= 1'b0;
    end else begin
      serial_rx_clock_o <= t2ctrl_r[ttc_pkg::C2_RCK] ? ovf2 : ovf1; // [R14] [R11]
      serial_tx_clock_o <= t2ctrl_r[ttc_pkg::C2_TCK] ? ovf2 : ovf1; // [R15] [R11]
    end
  end

  assign timer0_overflow_flag_o = tctrl_r[ttc_pkg::TC_OV0];
  assign timer1_overflow_flag_o = tctrl_r[ttc_pkg::TC_OV1];
  assign timer2_overflow_flag_o = t2ctrl_r[ttc_pkg::C2_TF];
  assign timer2_trigger_flag_o  = t2ctrl_r[ttc_pkg::C2_EXF];

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= ttc_pkg::RST_BYTE;
    end else begin
      case (sfr_req_i.addr)
        ttc_pkg::ADDR_TCTRL:  sfr_rdata_o <= tctrl_r;
        ttc_pkg::ADDR_TMODE:  sfr_rdata_o <= tmode_r;
        ttc_pkg::ADDR_C0_LO:  sfr_rdata_o <= c0_lo_r;
        ttc_pkg::ADDR_C0_HI:  sfr_rdata_o <= c0_hi_r;
        ttc_pkg::ADDR_TL1:    sfr_rdata_o <= tl1_r;
        ttc_pkg::ADDR_TH1:    sfr_rdata_o <= th1_r;
        ttc_pkg::ADDR_T2CTRL: sfr_rdata_o <= t2ctrl_r;
        ttc_pkg::ADDR_RLD_LO: sfr_rdata_o <= rld_lo_r;
        ttc_pkg::ADDR_RLD_HI: sfr_rdata_o <= rld_hi_r;
        ttc_pkg::ADDR_C2_LO:  sfr_rdata_o <= c2_lo_r;
        ttc_pkg::ADDR_C2_HI:  sfr_rdata_o <= c2_hi_r;
        default:              sfr_rdata_o <= ttc_pkg::RST_BYTE;
      endcase
    end
  end
endmodule : ttc_top
`default_nettype wire

// ===== verif/ttc_checker_assertions.sv
// checker: port assertions for the timer unit
`timescale 1ns/100ps
`default_nettype none
module ttc_checker (
  input wire logic                  sys_clk_i,
  input wire logic                  rstn_i,
  input wire ttc_pkg::ttc_sfr_req_t sfr_req_i,
  input wire logic                  timer0_int_ack_i,
  input wire logic                  timer1_int_ack_i,
  input wire logic [7:0]            sfr_rdata_o,
  input wire logic                  timer0_overflow_flag_o,
  input wire logic                  timer1_overflow_flag_o,
  input wire logic                  timer2_overflow_flag_o,
  input wire logic                  timer2_trigger_flag_o,
  input wire logic                  serial_rx_clock_o,
  input wire logic                  serial_tx_clock_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic w2c;
  logic wtc;
  logic rck_r;
  logic tck_r;
  logic exe_r;
  logic split_r;
  assign w2c = sfr_req_i.wr && (sfr_req_i.addr == ttc_pkg::ADDR_T2CTRL);
  assign wtc = sfr_req_i.wr && (sfr_req_i.addr == ttc_pkg::ADDR_TCTRL);
  // ------------------------------------------------------------
  // shadow of software written control bits
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {rck_r, tck_r, exe_r} <= 3'h0;
    end else if (w2c) begin
      {rck_r, tck_r, exe_r} <= sfr_req_i.wdata[5:3];
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      split_r <= 1'b0;
    end else if (sfr_req_i.wr && (sfr_req_i.addr == ttc_pkg::ADDR_TMODE)) begin
      split_r <= (sfr_req_i.wdata[1:0] == ttc_pkg::MODE_SPLIT);
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_OVF2_NOT_SERIAL: assert property ($rose(timer2_overflow_flag_o) && !$past(w2c) |-> !$past(rck_r | tck_r))
    else $error("timer 2 flag set while clocking serial port");
  AST_OVF2_SW_CLEAR: assert property ($fell(timer2_overflow_flag_o) |-> $past(w2c))
    else $error("timer 2 flag cleared without write");
  AST_EXF_SW_CLEAR: assert property ($fell(timer2_trigger_flag_o) |-> $past(w2c))
    else $error("trigger flag cleared without write");
  AST_EXF_ENABLED: assert property ($rose(timer2_trigger_flag_o) && !$past(w2c) |-> $past(exe_r))
    else $error("trigger flag set while trigger disabled");
  AST_OVF0_CLEAR: assert property ($fell(timer0_overflow_flag_o) |-> $past(timer0_int_ack_i) || $past(wtc))
    else $error("timer 0 flag cleared without ack or write");
  AST_OVF1_CLEAR: assert property ($fell(timer1_overflow_flag_o) |-> $past(timer1_int_ack_i) || $past(wtc))
    else $error("timer 1 flag cleared without ack or write");
  AST_RX_FROM_T1: assert property ($rose(timer1_overflow_flag_o) && !$past(wtc | rck_r | split_r) |-> serial_rx_clock_o)
    else $error("receive clock missing after timer 1 overflow");
  AST_TX_FROM_T1: assert property ($rose(timer1_overflow_flag_o) && !$past(wtc | tck_r | split_r) |-> serial_tx_clock_o)
    else $error("transmit clock missing after timer 1 overflow");
  AST_RD_C2_FLAGS: assert property ($past(sfr_req_i.addr) == ttc_pkg::ADDR_T2CTRL |-> sfr_rdata_o[7:6] == $past({timer2_overflow_flag_o, timer2_trigger_flag_o}))
    else $error("timer 2 control read disagrees with flags");
  COV_OVF2: cover property ($rose(timer2_overflow_flag_o));
  COV_EXF: cover property ($rose(timer2_trigger_flag_o));
  COV_RX: cover property (serial_rx_clock_o && rck_r);
endmodule : ttc_checker
`default_nettype wire

// ===== verif/ttc_pin_model.sv
// partner model: trigger pin of timer 2, idle high
`timescale 1ns/100ps
`default_nettype none
module ttc_pin_model (
  input  wire logic sys_clk_i,
  input  wire logic trig_go_i,
  output logic      timer2_trigger_pin_o
);
  initial timer2_trigger_pin_o = 1'b1;
  // one falling edge, held low long enough to be sampled
  always @(posedge trig_go_i) begin
    @(negedge sys_clk_i);
    timer2_trigger_pin_o = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    timer2_trigger_pin_o = 1'b1;
  end
endmodule : ttc_pin_model
`default_nettype wire

// ===== verif/tb_triple_timer_counter_unit.sv
// testbench: directed scenarios for the triple timer counter unit
`timescale 1ns/100ps
`default_nettype none
module tb_triple_timer_counter_unit;
  logic                  sys_clk_i = 1'b0;
  logic                  rstn_i = 1'b0;
  ttc_pkg::ttc_sfr_req_t req = '0;
  logic                  ext_interrupt0_pin = 1'b1;
  logic                  ack0 = 1'b0;
  logic                  tg = 1'b0;
  logic                  trig;
  logic [7:0]            rdata;
  logic [7:0]            d;
  logic                  cp0 = 1'b1;
  logic                  cp2 = 1'b1;
  logic                  ovf0_f, ovf1_f, ovf2_f, exf, rxc, txc;
  int                    n_mismatch = 0;
  int                    samples_checked = 0;
  int                    rxn, txn;
  always #50 sys_clk_i = ~sys_clk_i;
  ttc_top uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sfr_req_i(req),
    .ext_interrupt0_pin_i(ext_interrupt0_pin), .ext_interrupt1_pin_i(1'b1), .timer0_count_pin_i(cp0),
    .timer1_count_pin_i(1'b1), .timer2_count_pin_i(cp2), .timer2_trigger_pin_i(trig),
    .timer0_int_ack_i(ack0), .timer1_int_ack_i(1'b0), .sfr_rdata_o(rdata),
    .timer0_overflow_flag_o(ovf0_f), .timer1_overflow_flag_o(ovf1_f), .timer2_overflow_flag_o(ovf2_f),
    .timer2_trigger_flag_o(exf), .serial_rx_clock_o(rxc), .serial_tx_clock_o(txc));
  ttc_pin_model pins (.sys_clk_i(sys_clk_i), .trig_go_i(tg), .timer2_trigger_pin_o(trig));
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req = '{addr: a, wr: 1'b1, wdata: v};
    @(negedge sys_clk_i);
    req.wr = 1'b0;
    @(negedge sys_clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    req.addr = a;
    @(negedge sys_clk_i);
    d = rdata;
    chk(what, exp, d);
  endtask : rd
  task automatic poll(ref logic f);
    for (int i = 0; i < 60 && f !== 1'b1; i++) @(negedge sys_clk_i);
    if (f !== 1'b1) begin
      n_mismatch++;
      $display("BAD flag wait expected 1 seen %b", f);
      end_sim();
    end
  endtask : poll
  task automatic fire;
    tg = 1'b1;
    @(negedge sys_clk_i);
    tg = 1'b0;
    repeat (10) @(negedge sys_clk_i);
  endtask : fire
  task automatic t2_reload;
    rd(8'hc8, 8'h00, "t2 control reset");
    wr(8'h90, 8'h55);
    rd(8'h90, 8'h00, "unmapped");
    wr(8'hca, 8'h34);
    wr(8'hcb, 8'h12);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    chk("tf2", 8'h01, {7'h0, ovf2_f});
    wr(8'hc8, 8'h00);
    rd(8'hcc, 8'h35, "t2 low");
    rd(8'hcd, 8'h12, "t2 high");
    rd(8'hcc, 8'h35, "t2 stopped");
    rd(8'hc8, 8'h00, "t2 flag cleared");
  endtask : t2_reload
  task automatic t2_capture;
    wr(8'hcc, 8'h56);
    wr(8'hcd, 8'h78);
    wr(8'hc8, 8'h01);
    fire();
    rd(8'hc8, 8'h01, "trigger ignored");
    rd(8'hca, 8'h34, "no capture");
    wr(8'hc8, 8'h09);
    fire();
    rd(8'hc8, 8'h49, "trigger flag");
    chk("trigger flag out", 8'h01, {7'h0, exf});
    rd(8'hca, 8'h56, "capture low");
    rd(8'hcb, 8'h78, "capture high");
    wr(8'hc8, 8'h00);
    rd(8'hc8, 8'h00, "trigger flag cleared");
  endtask : t2_capture
  task automatic t2_baud;
    wr(8'hca, 8'hf0);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hf0);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h35);
    rxn = 0;
    txn = 0;
    repeat (64) begin
      @(negedge sys_clk_i);
      rxn += int'(rxc === 1'b1);
      txn += int'(txc === 1'b1);
    end
    chk("tf2 in baud mode", 8'h00, {7'h0, ovf2_f});
    chk("rx pulses", 8'h01, {7'h0, rxn >= 3 && rxn <= 5});
    chk("tx pulses", 8'(rxn), 8'(txn));
    wr(8'hc8, 8'h00);
  endtask : t2_baud
  task automatic cnt_pins;
    wr(8'h89, 8'h05);
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'h88, 8'h10);
    wr(8'hc8, 8'h06);
    repeat (3) begin
      {cp0, cp2} = 2'h0;
      repeat (2) @(negedge sys_clk_i);
      {cp0, cp2} = 2'h3;
      repeat (2) @(negedge sys_clk_i);
    end
    rd(8'h8a, 8'h03, "t0 pin count");
    rd(8'hcc, 8'h03, "t2 pin count");
    wr(8'h88, 8'h00);
    wr(8'hc8, 8'h08);
    fire();
    rd(8'hcc, 8'hf0, "t2 trigger reload");
    wr(8'hc8, 8'h00);
  endtask : cnt_pins
  task automatic t01_modes;
    wr(8'h89, 8'h11);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    wr(8'h8b, 8'hff);
    wr(8'h8d, 8'hff);
    wr(8'h88, 8'h50);
    poll(ovf0_f);
    rd(8'h8c, 8'h00, "t0 high wrapped");
    chk("tf1", 8'h01, {7'h0, ovf1_f});
    ack0 = 1'b1;
    @(negedge sys_clk_i);
    ack0 = 1'b0;
    @(negedge sys_clk_i);
    chk("tf0 after ack", 8'h00, {7'h0, ovf0_f});
    wr(8'h89, 8'h00);
    wr(8'h8c, 8'h00);
    wr(8'h8a, 8'h1e);
    wr(8'h88, 8'h10);
    for (int i = 0; i < 40 && d !== 8'h01; i++) begin
      req.addr = 8'h8c;
      @(negedge sys_clk_i);
      d = rdata;
    end
    wr(8'h88, 8'h00);
    chk("t0 high", 8'h01, d);
    req.addr = 8'h8a;
    @(negedge sys_clk_i);
    chk("t0 low five", 8'h00, {3'h0, rdata[4:0]});
    ext_interrupt0_pin = 1'b0;
    wr(8'h89, 8'h09);
    wr(8'h8a, 8'h00);
    wr(8'h88, 8'h10);
    repeat (40) @(negedge sys_clk_i);
    rd(8'h8a, 8'h00, "gated low");
    ext_interrupt0_pin = 1'b1;
    repeat (40) @(negedge sys_clk_i);
    wr(8'h88, 8'h00);
    req.addr = 8'h8a;
    @(negedge sys_clk_i);
    chk("gate open counts", 8'h01, {7'h0, rdata != 8'h00});
    wr(8'h89, 8'h02);
    wr(8'h8c, 8'hf0);
    wr(8'h8a, 8'hff);
    wr(8'h88, 8'h10);
    poll(ovf0_f);
    rd(8'h8a, 8'hf0, "reloaded low");
    rd(8'h8c, 8'hf0, "reload source");
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h33);
    wr(8'h8b, 8'h05);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h40);
    poll(ovf1_f);
    chk("tf0 split", 8'h00, {7'h0, ovf0_f});
    rd(8'h8b, 8'h05, "t1 held");
    wr(8'h88, 8'h00);
  endtask : t01_modes
  initial begin
    repeat (12) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    @(negedge sys_clk_i);
    t2_reload();
    t2_capture();
    t2_baud();
    cnt_pins();
    t01_modes();
    end_sim();
  end
endmodule : tb_triple_timer_counter_unit
bind ttc_top ttc_checker chk_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sfr_req_i(sfr_req_i),
  .timer0_int_ack_i(timer0_int_ack_i), .timer1_int_ack_i(timer1_int_ack_i), .sfr_rdata_o(sfr_rdata_o),
  .timer0_overflow_flag_o(timer0_overflow_flag_o), .timer1_overflow_flag_o(timer1_overflow_flag_o),
  .timer2_overflow_flag_o(timer2_overflow_flag_o), .timer2_trigger_flag_o(timer2_trigger_flag_o),
  .serial_rx_clock_o(serial_rx_clock_o), .serial_tx_clock_o(serial_tx_clock_o));
`default_nettype wire
